// ### src/cmt_pkg.sv
// constants, register map and carrier types of the compare-match timer
package cmt_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // register indices on the bus
    localparam logic [2:0] IDX_COUNT_HIGH   = 3'h0;
    localparam logic [2:0] IDX_COUNT_LOW    = 3'h1;
    localparam logic [2:0] IDX_COMPARE_HIGH = 3'h2;
    localparam logic [2:0] IDX_COMPARE_LOW  = 3'h3;
    localparam logic [2:0] IDX_CONTROL      = 3'h4;
    localparam logic [2:0] IDX_STATUS       = 3'h5;
    localparam logic [2:0] IDX_EDGE_SELECT  = 3'h6;
    localparam logic [2:0] IDX_IRQ_ENABLE   = 3'h7;

    // timer_control_status bit positions
    localparam int unsigned BIT_OVF_HIGH   = 7;
    localparam int unsigned BIT_MATCH_HIGH = 6;
    localparam int unsigned BIT_OVIE_HIGH  = 5;
    localparam int unsigned BIT_CLR_HIGH   = 4;
    localparam int unsigned BIT_OVF_LOW    = 3;
    localparam int unsigned BIT_MATCH_LOW  = 2;
    localparam int unsigned BIT_OVIE_LOW   = 1;
    localparam int unsigned BIT_CLR_LOW    = 0;
    localparam logic [7:0]  STATUS_RW_MASK = 8'h33;

    // edge_select_reg and irq_enable_reg2 bit positions
    localparam int unsigned BIT_EVENT_EDGE  = 0;
    localparam int unsigned BIT_IRQ_EN_LOW  = 0;
    localparam int unsigned BIT_IRQ_EN_HIGH = 1;

    // reset values
    localparam logic [15:0] RST_COUNT    = 16'h0000;
    localparam logic [15:0] RST_COMPARE  = 16'hffff;
    localparam logic [7:0]  RST_CONTROL  = 8'h00;
    localparam logic [7:0]  RST_STATUS   = 8'h00;
    localparam logic [7:0]  RST_EDGE     = 8'h00;
    localparam logic [7:0]  RST_IRQ_EN   = 8'h00;
    localparam logic [7:0]  BYTE_ONES    = 8'hff;

    // prescaler terminal counts
    localparam int unsigned SYS_DIV_W  = 5;
    localparam logic [4:0]  DIV32_LAST = 5'h1f;
    localparam logic [3:0]  DIV16_LAST = 4'hf;
    localparam logic [1:0]  DIV4_LAST  = 2'h3;
    localparam logic [1:0]  SUB4_LAST  = 2'h3;

    // clock select codes; msb clear picks the event pin
    typedef enum logic [2:0] {
        CKS_DIV32 = 3'b100,
        CKS_DIV16 = 3'b101,
        CKS_DIV4  = 3'b110,
        CKS_SUB4  = 3'b111
    } cmt_clk_sel_t;

    // timer_control field layout
    typedef struct packed {
        logic       out_level_high;
        logic [2:0] high_clock_sel;
        logic       out_level_low;
        logic [2:0] low_clock_sel;
    } cmt_ctrl_t;

    // count enables of the two halves
    typedef struct packed {
        logic high;
        logic low;
    } cmt_ticks_t;

endpackage : cmt_pkg

// ### src/cmt_tick_gen.sv
// count-enable generator: prescaler, subclock synchroniser, event edge
`timescale 1ns/1ps
module cmt_tick_gen
    import cmt_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // sources
    input  wire logic       i_sub_clk,
    input  wire logic       i_event_in_pin,
    input  wire logic       i_event_edge_sel,
    // selection and power state
    input  wire logic [2:0] i_high_clock_sel,
    input  wire logic [2:0] i_low_clock_sel,
    input  wire logic       i_sub_mode,
    input  wire logic       i_standby,
    // count enables
    output cmt_ticks_t      o_ticks
);

    logic [SYS_DIV_W-1:0] div_cnt, next_div_cnt;
    logic                 sub_meta, sub_sync, sub_last;
    logic [1:0]           sub_cnt, next_sub_cnt;
    logic                 event_last;
    logic                 sub_edge, sub_tick, event_tick;
    logic [1:0][2:0]      sel;
    logic [1:0]           raw_tick;

    // free prescaler and subclock divide-by-four
    always_comb begin
        sub_edge     = sub_sync & ~sub_last;
        sub_tick     = sub_edge && (sub_cnt == SUB4_LAST);
        next_div_cnt = div_cnt + 5'h01;
        next_sub_cnt = sub_edge ? sub_cnt + 2'h1 : sub_cnt;
        event_tick   = i_event_edge_sel ? (i_event_in_pin & ~event_last)
                                        : (~i_event_in_pin & event_last);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_cnt    <= '0;
            sub_meta   <= 1'b0;
            sub_sync   <= 1'b0;
            sub_last   <= 1'b0;
            sub_cnt    <= 2'h0;
            event_last <= 1'b0;
        end else begin
            div_cnt    <= next_div_cnt;
            sub_meta   <= i_sub_clk;
            sub_sync   <= sub_meta;
            sub_last   <= sub_sync;
            sub_cnt    <= next_sub_cnt;
            event_last <= i_event_in_pin;
        end
    end

    assign sel = {i_high_clock_sel, i_low_clock_sel};

    // per-half source mux and power-state gating
    for (genvar ch = 0; ch < 2; ch++) begin : g_half
        always_comb begin
            case (sel[ch])
                CKS_DIV32: raw_tick[ch] = (div_cnt == DIV32_LAST) && !i_sub_mode;
                CKS_DIV16: raw_tick[ch] = (div_cnt[3:0] == DIV16_LAST) && !i_sub_mode;
                CKS_DIV4:  raw_tick[ch] = (div_cnt[1:0] == DIV4_LAST) && !i_sub_mode;
                CKS_SUB4:  raw_tick[ch] = sub_tick;
                default:   raw_tick[ch] = event_tick;
            endcase
        end
    end

    assign o_ticks.high = raw_tick[1] & ~i_standby;
    assign o_ticks.low  = raw_tick[0] & ~i_standby;

    property p_standby_halts;
        @(posedge i_clk) disable iff (!i_arst_n)
        i_standby |-> (o_ticks == 2'b00);
    endproperty
    a_standby_halts: assert property (p_standby_halts) else $error("tick during standby");

endmodule : cmt_tick_gen

// ### src/cmt_timer.sv
// compare-match timer: one 16-bit or two 8-bit counters with register port
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - ovf_irq_en_low gates the low overflow interrupt; resets to 0.
// - match_clear_low set makes a low compare match clear the low counter in 8-bit mode.
// - flags clear only by writing 0 after reading 1; writing 1 ignored.
// - high_clock_sel_msb 0 chains both halves into one 16-bit counter.
// - reset gives count 0000, compare ffff, control and status 00.
// - event source counts on the pin edge chosen by event_edge_sel.
// - 16-bit match sets match_flag_high; irq_en_high adds request and toggle.
// - 16-bit match clears whole count when match_clear_high is 1.
// - 16-bit wrap sets ovf_flag_high; request needs both enables.
// - high_clock_sel_msb 1 runs two independent 8-bit counters.
// - 8-bit half match sets flag, requests, toggles, clears per its bits.
// - 8-bit half wrap sets its overflow flag; request needs both enables.
// - internal sources are system clock /32, /16, /4 or subclock /4.
// - select 101 is /16, 110 is /4, 111 is subclock /4.
// - low_clock_sel_msb 0 picks the event pin for the low counter.
// - compare pins start at their level bit, then invert on each match while their irq enable bit is set.
// - match fires when the counter leaves the matching value.
// - subclock count source passes a synchroniser into the system clock.
// - in sub modes only subclock /4 and the event pin advance the counter.
module cmt_timer
    import cmt_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    // pins
    input  wire logic              i_event_in_pin,
    input  wire logic              i_sub_clk,
    output logic                   o_toggle_out_high,
    output logic                   o_toggle_out_low,
    // power state
    input  wire logic              i_sub_mode,
    input  wire logic              i_standby,
    // interrupt requests to the cpu
    output logic                   o_irq_high,
    output logic                   o_irq_low
);

    logic [15:0]       count_register, next_count_register;
    logic [15:0]       compare_value, next_compare_value;
    logic [7:0]        timer_control, next_timer_control;
    logic [7:0]        timer_control_status, next_timer_control_status;
    logic [7:0]        edge_select_reg, next_edge_select_reg;
    logic [7:0]        irq_enable_reg2, next_irq_enable_reg2;
    logic [7:0]        flag_armed, next_flag_armed;
    logic [7:0]        flag_set, flag_clr;
    logic [DATA_W-1:0] next_rdata;
    logic              next_toggle_high, next_toggle_low, next_irq_high, next_irq_low;
    cmt_ctrl_t         ctrl;
    cmt_ticks_t        ticks;
    logic              mode16, irq_en_high, irq_en_low;
    logic              wr_cnt_h, wr_cnt_l, wr_cmp_h, wr_cmp_l, wr_ctrl, wr_stat;
    logic              high_match, low_match, high_ovf, low_ovf;
    logic              high_clear, low_clear;

    assign ctrl        = cmt_ctrl_t'(timer_control);
    assign mode16      = ~ctrl.high_clock_sel[2];
    assign irq_en_high = irq_enable_reg2[BIT_IRQ_EN_HIGH];
    assign irq_en_low  = irq_enable_reg2[BIT_IRQ_EN_LOW];
    assign wr_cnt_h    = i_wr && (i_addr == IDX_COUNT_HIGH);
    assign wr_cnt_l    = i_wr && (i_addr == IDX_COUNT_LOW);
    assign wr_cmp_h    = i_wr && (i_addr == IDX_COMPARE_HIGH);
    assign wr_cmp_l    = i_wr && (i_addr == IDX_COMPARE_LOW);
    assign wr_ctrl     = i_wr && (i_addr == IDX_CONTROL);
    assign wr_stat     = i_wr && (i_addr == IDX_STATUS);

    cmt_tick_gen u_tick_gen (
        .i_clk            (i_clk),
        .i_arst_n         (i_arst_n),
        .i_sub_clk        (i_sub_clk),
        .i_event_in_pin   (i_event_in_pin),
        .i_event_edge_sel (edge_select_reg[BIT_EVENT_EDGE]),
        .i_high_clock_sel (ctrl.high_clock_sel),
        .i_low_clock_sel  (ctrl.low_clock_sel),
        .i_sub_mode       (i_sub_mode),
        .i_standby        (i_standby),
        .o_ticks          (ticks)
    );

    // match and wrap events, taken on the tick that leaves the value
    always_comb begin
        if (mode16) begin
            high_match = ticks.low && (count_register == compare_value)
                         && !wr_cmp_l && !wr_cmp_h;
            high_clear = high_match && timer_control_status[BIT_CLR_HIGH];
            low_clear  = high_clear;
            high_ovf   = ticks.low && (count_register == 16'hffff)
                         && !high_clear && !wr_cnt_h && !wr_cnt_l;
        end else begin
            high_match = ticks.high && (count_register[15:8] == compare_value[15:8])
                         && !wr_cmp_h;
            high_clear = high_match && timer_control_status[BIT_CLR_HIGH];
            low_clear  = 1'b0;
            high_ovf   = ticks.high && (count_register[15:8] == BYTE_ONES)
                         && !high_clear && !wr_cnt_h;
        end
        low_match = ticks.low && (count_register[7:0] == compare_value[7:0]) && !wr_cmp_l;
        if (!mode16) begin
            low_clear = low_match && timer_control_status[BIT_CLR_LOW];
        end
        low_ovf = ticks.low && (count_register[7:0] == BYTE_ONES) && !low_clear && !wr_cnt_l;
    end

    // counter next value: software write beats counting
    always_comb begin
        next_count_register = count_register;
        if (mode16) begin
            if (ticks.low) begin
                next_count_register = high_clear ? RST_COUNT
                                                 : count_register + 16'h0001;
            end
        end else begin
            if (ticks.high) begin
                next_count_register[15:8] = high_clear ? 8'h00
                                                       : count_register[15:8] + 8'h01;
            end
            if (ticks.low) begin
                next_count_register[7:0] = low_clear ? 8'h00 : count_register[7:0] + 8'h01;
            end
        end
        if (wr_cnt_h) begin
            next_count_register[15:8] = i_wdata;
        end
        if (wr_cnt_l) begin
            next_count_register[7:0] = i_wdata;
        end
    end

    // flag set sources and clear-after-read handling
    always_comb begin
        flag_set = 8'h00;
        flag_set[BIT_OVF_HIGH]   = high_ovf;
        flag_set[BIT_MATCH_HIGH] = high_match;
        flag_set[BIT_OVF_LOW]    = low_ovf;
        flag_set[BIT_MATCH_LOW]  = low_match;
        flag_clr = wr_stat ? (~i_wdata & flag_armed & ~STATUS_RW_MASK) : 8'h00;
        next_timer_control_status = (timer_control_status & ~flag_clr) | flag_set;
        if (wr_stat) begin
            next_timer_control_status = (next_timer_control_status & ~STATUS_RW_MASK)
                                        | (i_wdata & STATUS_RW_MASK);
        end
        // a read arms the flags that were seen as one; a clear disarms them
        if (i_rd && (i_addr == IDX_STATUS)) begin
            next_flag_armed = timer_control_status & ~STATUS_RW_MASK;
        end else begin
            next_flag_armed = flag_armed & next_timer_control_status;
        end
    end

    // other registers and pin/request outputs
    always_comb begin
        next_compare_value   = compare_value;
        next_timer_control   = timer_control;
        next_edge_select_reg = edge_select_reg;
        next_irq_enable_reg2 = irq_enable_reg2;
        if (wr_cmp_h) next_compare_value[15:8] = i_wdata;
        if (wr_cmp_l) next_compare_value[7:0]  = i_wdata;
        if (wr_ctrl) next_timer_control = i_wdata;
        if (i_wr && (i_addr == IDX_EDGE_SELECT)) next_edge_select_reg = i_wdata & 8'h01;
        if (i_wr && (i_addr == IDX_IRQ_ENABLE)) next_irq_enable_reg2 = i_wdata & 8'h03;
        if (wr_ctrl) begin
            next_toggle_high = i_wdata[7];
            next_toggle_low  = i_wdata[3];
        end else begin
            next_toggle_high = o_toggle_out_high ^ (high_match & irq_en_high);
            next_toggle_low  = o_toggle_out_low ^ (low_match & irq_en_low);
        end
        next_irq_high = irq_en_high & (high_match
                        | (high_ovf & timer_control_status[BIT_OVIE_HIGH]));
        next_irq_low  = irq_en_low & (low_match
                        | (low_ovf & timer_control_status[BIT_OVIE_LOW]));
    end

    // read data for the cycle after the strobe only
    always_comb begin
        next_rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                IDX_COUNT_HIGH:   next_rdata = count_register[15:8];
                IDX_COUNT_LOW:    next_rdata = count_register[7:0];
                IDX_COMPARE_HIGH: next_rdata = compare_value[15:8];
                IDX_COMPARE_LOW:  next_rdata = compare_value[7:0];
                IDX_CONTROL:      next_rdata = timer_control;
                IDX_STATUS:       next_rdata = timer_control_status;
                IDX_EDGE_SELECT:  next_rdata = edge_select_reg;
                IDX_IRQ_ENABLE:   next_rdata = irq_enable_reg2;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_register       <= RST_COUNT;
            compare_value        <= RST_COMPARE;
            timer_control        <= RST_CONTROL;
            timer_control_status <= RST_STATUS;
            edge_select_reg      <= RST_EDGE;
            irq_enable_reg2      <= RST_IRQ_EN;
            flag_armed           <= 8'h00;
            o_rdata              <= 8'h00;
            o_toggle_out_high    <= 1'b0;
            o_toggle_out_low     <= 1'b0;
            o_irq_high           <= 1'b0;
            o_irq_low            <= 1'b0;
        end else begin
            count_register       <= next_count_register;
            compare_value        <= next_compare_value;
            timer_control        <= next_timer_control;
            timer_control_status <= next_timer_control_status;
            edge_select_reg      <= next_edge_select_reg;
            irq_enable_reg2      <= next_irq_enable_reg2;
            flag_armed           <= next_flag_armed;
            o_rdata              <= next_rdata;
            o_toggle_out_high    <= next_toggle_high;
            o_toggle_out_low     <= next_toggle_low;
            o_irq_high           <= next_irq_high;
            o_irq_low            <= next_irq_low;
        end
    end

    // checks
    property p_ovie_low_gate;
        @(posedge i_clk) disable iff (!i_arst_n)
        (low_ovf && !timer_control_status[BIT_OVIE_LOW] && !low_match) |=> !o_irq_low;
    endproperty
    a_ovie_low_gate: assert property (p_ovie_low_gate) else $error("low irq not gated");

    property p_low_clear;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!mode16 && low_match && timer_control_status[BIT_CLR_LOW] && !wr_cnt_l)
            |=> (count_register[7:0] == 8'h00);
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("low half not cleared");

    property p_write_one_keeps;
        @(posedge i_clk) disable iff (!i_arst_n)
        (wr_stat && i_wdata[BIT_OVF_HIGH] && timer_control_status[BIT_OVF_HIGH])
            |=> timer_control_status[BIT_OVF_HIGH];
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag lost");

    property p_full_clear;
        @(posedge i_clk) disable iff (!i_arst_n)
        (mode16 && high_match && timer_control_status[BIT_CLR_HIGH] && !wr_cnt_h && !wr_cnt_l)
            |=> (count_register == 16'h0000);
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("16-bit not cleared");

    property p_full_wrap;
        @(posedge i_clk) disable iff (!i_arst_n)
        (mode16 && ticks.low && count_register == 16'hffff && !high_clear && !i_wr)
            |=> (timer_control_status[BIT_OVF_HIGH] && count_register == 16'h0000);
    endproperty
    a_full_wrap: assert property (p_full_wrap) else $error("16-bit wrap missed");

    property p_match_on_leave;
        @(posedge i_clk) disable iff (!i_arst_n)
        (mode16 && $rose(timer_control_status[BIT_MATCH_HIGH]))
            |-> ($past(count_register) == $past(compare_value)) && $past(ticks.low);
    endproperty
    a_match_on_leave: assert property (p_match_on_leave) else $error("early match");

    property p_match_toggle;
        @(posedge i_clk) disable iff (!i_arst_n)
        (high_match && irq_en_high && !wr_ctrl)
            |=> (o_toggle_out_high != $past(o_toggle_out_high)) && o_irq_high;
    endproperty
    a_match_toggle: assert property (p_match_toggle) else $error("no toggle on match");

    property p_level_load;
        @(posedge i_clk) disable iff (!i_arst_n)
        wr_ctrl |=> (o_toggle_out_high == $past(i_wdata[7]))
                    && (o_toggle_out_low == $past(i_wdata[3]));
    endproperty
    a_level_load: assert property (p_level_load) else $error("level not loaded");

    property p_low_wrap8;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!mode16 && ticks.low && count_register[7:0] == BYTE_ONES && !low_clear && !wr_cnt_l)
            |=> timer_control_status[BIT_OVF_LOW];
    endproperty
    a_low_wrap8: assert property (p_low_wrap8) else $error("low wrap missed");

endmodule : cmt_timer

// ### bench/cmt_event_src.sv
// far-side model: external event source and watch subclock level
`timescale 1ns/1ps
module cmt_event_src (
    // clock
    input  wire logic i_clk,
    // pins toward the timer
    output logic      o_event_in_pin,
    output logic      o_sub_clk
);
    // idle levels; subclock edges land off the system clock edges
    initial begin
        o_event_in_pin = 1'b0;
        o_sub_clk      = 1'b0;
        #1;
        forever #60 o_sub_clk = ~o_sub_clk;
    end

    // one event: high then low for three clocks each, never shorter
    task automatic pulse();
        repeat (3) @(posedge i_clk) o_event_in_pin <= 1'b1;
        repeat (3) @(posedge i_clk) o_event_in_pin <= 1'b0;
    endtask : pulse
endmodule : cmt_event_src

// ### bench/cmt_timer_test.sv
// self-checking bench of the compare-match timer over its register port
`timescale 1ns/1ps
module cmt_timer_test;
    import cmt_pkg::*;
    logic              i_clk;
    logic              i_arst_n;
    logic              i_wr;
    logic              i_rd;
    logic              i_sub_mode;
    logic              i_standby;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic [DATA_W-1:0] o_rdata;
    logic              ev;
    logic              sub;
    logic              tog_h;
    logic              tog_l;
    logic              irq_h;
    logic              irq_l;
    int                error_cnt    = 0;
    int                total_checks = 0;
    int                irq_l_cnt    = 0;
    int                irq_h_cnt    = 0;

    cmt_timer cmt_timer_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_event_in_pin(ev), .i_sub_clk(sub), .o_toggle_out_high(tog_h),
        .o_toggle_out_low(tog_l), .i_sub_mode(i_sub_mode), .i_standby(i_standby),
        .o_irq_high(irq_h), .o_irq_low(irq_l));
    cmt_event_src cmt_event_src_i (.i_clk(i_clk), .o_event_in_pin(ev), .o_sub_clk(sub));

    // system clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // count interrupt pulses of both halves
    always @(posedge i_clk) begin
        if (irq_l === 1'b1) irq_l_cnt <= irq_l_cnt + 1;
        if (irq_h === 1'b1) irq_h_cnt <= irq_h_cnt + 1;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        @(negedge i_clk);
        check(o_rdata, exp);
    endtask : rd

    // count the high half from zero over n edges on one clock choice
    task automatic span(input logic [7:0] ctl, input int n, input logic [7:0] exp);
        wr(IDX_CONTROL, ctl);
        wr(IDX_COUNT_HIGH, 8'h00);
        repeat (n - 1) @(posedge i_clk);
        rd(IDX_COUNT_HIGH, exp);
    endtask : span

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // watchdog well beyond the five hundred and sixty or so cycles the tests need
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end

    // main sequence
    initial begin
        i_arst_n   = 1'b0;
        i_wr       = 1'b0;
        i_rd       = 1'b0;
        i_addr     = '0;
        i_wdata    = '0;
        i_sub_mode = 1'b0;
        i_standby  = 1'b0;
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(IDX_COUNT_HIGH, 8'h00);
        rd(IDX_COUNT_LOW, 8'h00);
        rd(IDX_COMPARE_HIGH, 8'hff);
        rd(IDX_COMPARE_LOW, 8'hff);
        rd(IDX_CONTROL, 8'h00);
        rd(IDX_STATUS, 8'h00);
        // writing ones reaches only enable and clear bits
        wr(IDX_STATUS, 8'hff);
        rd(IDX_STATUS, 8'h33);
        wr(IDX_STATUS, 8'h00);
        // chained 16-bit count of rising event edges, then standby halt
        wr(IDX_EDGE_SELECT, 8'h01);
        wr(IDX_COUNT_LOW, 8'hfe);
        repeat (2) cmt_event_src_i.pulse();
        rd(IDX_COUNT_HIGH, 8'h01);
        rd(IDX_COUNT_LOW, 8'h00);
        rd(IDX_STATUS, 8'h0c);
        @(posedge i_clk) i_standby <= 1'b1;
        cmt_event_src_i.pulse();
        rd(IDX_COUNT_LOW, 8'h00);
        @(posedge i_clk) i_standby <= 1'b0;
        // clear the armed low overflow and low match flags
        wr(IDX_STATUS, 8'h00);
        rd(IDX_STATUS, 8'h00);
        // 8-bit mode: low half on events with clear on match
        wr(IDX_CONTROL, 8'h48);
        @(negedge i_clk);
        check({7'h0, tog_l}, 8'h01);
        wr(IDX_COUNT_LOW, 8'h00);
        wr(IDX_COMPARE_LOW, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h01);
        wr(IDX_STATUS, 8'h01);
        cmt_event_src_i.pulse();
        rd(IDX_STATUS, 8'h01);
        cmt_event_src_i.pulse();
        rd(IDX_STATUS, 8'h05);
        rd(IDX_COUNT_LOW, 8'h00);
        check({7'h0, tog_l}, 8'h00);
        check(irq_l_cnt[7:0], 8'h01);
        // low overflow with its request enabled, then blocked
        wr(IDX_STATUS, 8'h02);
        wr(IDX_COUNT_LOW, 8'hff);
        cmt_event_src_i.pulse();
        rd(IDX_STATUS, 8'h0a);
        check(irq_l_cnt[7:0], 8'h02);
        wr(IDX_STATUS, 8'h00);
        wr(IDX_COUNT_LOW, 8'hff);
        cmt_event_src_i.pulse();
        rd(IDX_STATUS, 8'h08);
        check(irq_l_cnt[7:0], 8'h02);
        // 16-bit match with clear, request and toggle, then full wrap
        wr(IDX_CONTROL, 8'h80);
        @(negedge i_clk);
        check({7'h0, tog_h}, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h02);
        wr(IDX_COMPARE_HIGH, 8'h01);
        wr(IDX_COMPARE_LOW, 8'h00);
        wr(IDX_STATUS, 8'h10);
        wr(IDX_COUNT_HIGH, 8'h01);
        wr(IDX_COUNT_LOW, 8'h00);
        cmt_event_src_i.pulse();
        rd(IDX_STATUS, 8'h54);
        rd(IDX_COUNT_HIGH, 8'h00);
        check({7'h0, tog_h}, 8'h00);
        check(irq_h_cnt[7:0], 8'h01);
        wr(IDX_STATUS, 8'h20);
        wr(IDX_COUNT_HIGH, 8'hff);
        wr(IDX_COUNT_LOW, 8'hff);
        cmt_event_src_i.pulse();
        rd(IDX_STATUS, 8'ha8);
        check(irq_h_cnt[7:0], 8'h02);
        wr(IDX_STATUS, 8'hff);
        rd(IDX_STATUS, 8'hbb);
        // high half alone on each internal clock choice
        wr(IDX_COMPARE_HIGH, 8'hff);
        span(8'h60, 32, 8'h08);
        span(8'h50, 32, 8'h02);
        span(8'h40, 32, 8'h01);
        @(posedge i_clk) i_sub_mode <= 1'b1;
        span(8'h60, 32, 8'h00);
        span(8'h70, 240, 8'h04);
        report_and_stop();
    end
endmodule : cmt_timer_test
